/* rtl/spst_pkg.sv */
// constants, types and register layout for the scaler power, status and task control bank
package spst_pkg;

    // register subaddresses on the control-bus register port
    localparam logic [7:0] SPST_ADDR_POWER  = 8'h88;
    localparam logic [7:0] SPST_ADDR_STATUS = 8'h8F;
    localparam logic [7:0] SPST_ADDR_TASK_A = 8'h90;
    localparam logic [7:0] SPST_ADDR_TASK_B = 8'hC0;

    // reset values
    localparam logic [7:0] SPST_POWER_RESET = 8'h00;
    localparam logic [7:0] SPST_TASK_RESET  = 8'h00;
    localparam logic [7:0] SPST_RDATA_IDLE  = 8'h00;

    // power control field positions
    localparam int SPST_PWR_DECODER_SLEEP = 0;
    localparam int SPST_PWR_SCALER_SLEEP  = 1;
    localparam int SPST_PWR_AUDIO_PD      = 3;
    localparam int SPST_PWR_MARKER        = 4;
    localparam int SPST_PWR_SOFT_RESET    = 5;
    localparam int SPST_PWR_ADC_SEL_LO    = 6;
    localparam int SPST_ADC_SEL_W         = 2;

    // task handling control field positions
    localparam int SPST_TSK_POLARITY  = 7;
    localparam int SPST_TSK_FID_SEL   = 6;
    localparam int SPST_TSK_SKIP_LO   = 3;
    localparam int SPST_TSK_SKIP_W    = 3;
    localparam int SPST_TSK_TRIG_W    = 3;

    // synchroniser depth for pin inputs
    localparam int SPST_SYNC_STAGES = 2;

    typedef enum logic [1:0] {
        SPST_TS_IDLE = 2'b00,
        SPST_TS_SKIP = 2'b01,
        SPST_TS_RUN  = 2'b10
    } spst_task_state_t;

    // register port request from the control-bus slave
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } spst_reg_req_t;

    // live flags from the scaler core
    typedef struct packed {
        logic fifo_almost_filled_flag;
        logic fifo_overflow_flag;
        logic formatter_error_flag;
        logic input_field_id;
    } spst_scaler_flags_t;

    typedef struct packed {
        logic [7:0]                    power;
        logic [7:0]                    task_a;
        logic [7:0]                    task_b;
        logic [7:0]                    rdata;
        logic [SPST_SYNC_STAGES-1:0]   xside_tristate_pin_sync;
        logic [SPST_SYNC_STAGES-1:0]   image_out_tristate_pin_sync;
        spst_task_state_t              tstate;
        logic                          active_b;
        logic [SPST_TSK_SKIP_W-1:0]    skip_cnt;
        logic                          toggle;
        logic                          start;
        logic                          out_fid;
        logic                          sav_bit7;
    } spst_state_t;

endpackage : spst_pkg

/* rtl/spst_ctrl.sv */
// power-down controls, live scaler status byte and task field-id / field-skip handling
//
// How it works
// - decoder sleep powers down decoder; scaler runs only with X port input and clock.
// - scaler sleep powers down scaler and stops all image port output.
// - audio power-down bit stops audio clock generation and disables its output.
// - status byte is read-only, sampled live at each read; only pin bits 7 and 6 pass a two-stage synchroniser.
// - status bits 7 and 6 report the two tristate input pin levels.
// - status bit 5 is fifo almost filled, bit 4 is fifo overflow.
// - status bit 3 mirrors the programmed marker bit.
// - status bit 2 is the output formatter error flag.
// - status bit 1 is input field id, bit 0 output field id.
// - field id select 0 passes input field id; 1 passes toggling task flag.
// - polarity 0 drives SAV/EAV bit 7 and task flag high; 1 low.
// - field skip value delays task start by 0 to 7 fields.
// - programmed marker is 0 after reset; software sets it after programming.
// - soft reset bit 0 idles the scaler path; 1 runs it.
`timescale 1ns/10ps
module spst_ctrl
    import spst_pkg::*;
(
    input  wire logic               core_clk,
    input  wire logic               rst_n,
    input  wire spst_reg_req_t      reg_req,
    output logic [7:0]              reg_rdata,
    input  wire logic               xside_tristate_pin,
    input  wire logic               image_out_tristate_pin,
    input  wire spst_scaler_flags_t scaler_flags,
    input  wire logic               scaler_src_xport,
    input  wire logic               image_port_clock_xport,
    input  wire logic               field_pulse,
    input  wire logic               task_activate,
    input  wire logic               task_select_b,
    input  wire logic               task_done,
    output logic                    decoder_powerdown,
    output logic                    scaler_powerdown,
    output logic                    scaler_run,
    output logic                    image_out_enable,
    output logic                    audio_clk_powerdown,
    output logic                    audio_clk_out_en,
    output logic [SPST_ADC_SEL_W-1:0] adc_port_select,
    output logic                    task_start,
    output logic                    task_busy,
    output logic                    output_field_id,
    output logic                    sav_eav_bit7,
    output logic                    task_flag
);

    spst_state_t st;
    spst_state_t next_st;
    logic [7:0]  status_live;
    logic [7:0]  sel_task;
    logic [7:0]  new_task;
    logic        decoder_sleep;
    logic        scaler_sleep;
    logic        programmed_marker;
    logic        soft_run;

    assign decoder_sleep     = st.power[SPST_PWR_DECODER_SLEEP];
    assign scaler_sleep      = st.power[SPST_PWR_SCALER_SLEEP];
    assign programmed_marker = st.power[SPST_PWR_MARKER];
    assign soft_run          = st.power[SPST_PWR_SOFT_RESET];

    assign decoder_powerdown   = decoder_sleep;
    assign scaler_powerdown    = scaler_sleep;
    // with the decoder asleep only an X port fed, X port clocked scaler has data and clock
    assign scaler_run          = soft_run && !scaler_sleep
                                 && (!decoder_sleep
                                     || (scaler_src_xport && image_port_clock_xport));
    assign image_out_enable    = scaler_run;
    assign audio_clk_powerdown = st.power[SPST_PWR_AUDIO_PD];
    assign audio_clk_out_en    = !st.power[SPST_PWR_AUDIO_PD];
    assign adc_port_select     = st.power[SPST_PWR_ADC_SEL_LO +: SPST_ADC_SEL_W];

    assign reg_rdata       = st.rdata;
    assign task_start      = st.start;
    assign task_busy       = (st.tstate != SPST_TS_IDLE);
    assign output_field_id = st.out_fid;
    assign sav_eav_bit7    = st.sav_bit7;
    assign task_flag       = st.sav_bit7;

    // status byte is assembled from live flags, no capture stage of its own
    always_comb begin
        status_live = {st.xside_tristate_pin_sync[SPST_SYNC_STAGES-1],
                       st.image_out_tristate_pin_sync[SPST_SYNC_STAGES-1],
                       scaler_flags.fifo_almost_filled_flag,
                       scaler_flags.fifo_overflow_flag,
                       programmed_marker,
                       scaler_flags.formatter_error_flag,
                       scaler_flags.input_field_id,
                       st.out_fid};
    end

    always_comb begin
        next_st = st;
        sel_task = 8'h00;
        new_task = 8'h00;
        next_st.start = 1'b0;
        // pin levels come from outside the clock domain; only the second stage is ever read
        next_st.xside_tristate_pin_sync = {st.xside_tristate_pin_sync[SPST_SYNC_STAGES-2:0], xside_tristate_pin};
        next_st.image_out_tristate_pin_sync = {st.image_out_tristate_pin_sync[SPST_SYNC_STAGES-2:0], image_out_tristate_pin};

        // register writes; the status address and unmapped addresses fall through
        if (reg_req.wr) begin
            case (reg_req.addr)
                SPST_ADDR_POWER:  next_st.power  = reg_req.wdata;
                SPST_ADDR_TASK_A: next_st.task_a = reg_req.wdata;
                SPST_ADDR_TASK_B: next_st.task_b = reg_req.wdata;
                default:          next_st.power  = st.power;
            endcase
        end

        if (reg_req.rd) begin
            case (reg_req.addr)
                SPST_ADDR_POWER:  next_st.rdata = st.power;
                SPST_ADDR_STATUS: next_st.rdata = status_live;
                SPST_ADDR_TASK_A: next_st.rdata = st.task_a;
                SPST_ADDR_TASK_B: next_st.rdata = st.task_b;
                default:          next_st.rdata = SPST_RDATA_IDLE;
            endcase
        end

        // activation is decoded only while idle, so a request made while busy is dropped
        new_task = task_select_b ? st.task_b : st.task_a;

        case (st.tstate)
            SPST_TS_IDLE: begin
                if (task_activate) begin
                    next_st.active_b = task_select_b;
                    if (new_task[SPST_TSK_SKIP_LO +: SPST_TSK_SKIP_W] == 3'h0) begin
                        next_st.tstate = SPST_TS_RUN;
                        next_st.start  = 1'b1;
                        next_st.toggle = !st.toggle;
                    end else begin
                        next_st.tstate   = SPST_TS_SKIP;
                        next_st.skip_cnt = new_task[SPST_TSK_SKIP_LO +: SPST_TSK_SKIP_W];
                    end
                end
            end
            SPST_TS_SKIP: begin
                if (field_pulse) begin
                    if (st.skip_cnt == 3'h1) begin
                        next_st.tstate   = SPST_TS_RUN;
                        next_st.start    = 1'b1;
                        next_st.toggle   = !st.toggle;
                        next_st.skip_cnt = 3'h0;
                    end else begin
                        next_st.skip_cnt = st.skip_cnt - 3'h1;
                    end
                end
            end
            SPST_TS_RUN: begin
                if (task_done) begin
                    next_st.tstate = SPST_TS_IDLE;
                end
            end
            default: next_st.tstate = SPST_TS_IDLE;
        endcase

        // soft reset takes priority: a pending skip or running task is dropped
        if (!soft_run) begin
            next_st.tstate   = SPST_TS_IDLE;
            next_st.skip_cnt = 3'h0;
            next_st.start    = 1'b0;
            next_st.toggle   = st.toggle;
        end

        sel_task = next_st.active_b ? next_st.task_b : next_st.task_a;
        next_st.out_fid  = sel_task[SPST_TSK_FID_SEL] ? next_st.toggle
                                                      : scaler_flags.input_field_id;
        next_st.sav_bit7 = !sel_task[SPST_TSK_POLARITY];
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            st          <= '0;
            st.power    <= SPST_POWER_RESET;
            st.task_a   <= SPST_TASK_RESET;
            st.task_b   <= SPST_TASK_RESET;
            st.rdata    <= SPST_RDATA_IDLE;
            st.tstate   <= SPST_TS_IDLE;
            st.sav_bit7 <= 1'b1;
        end else begin
            st <= next_st;
        end
    end

    // checks
    a_status_write_ignored: assert property (@(posedge core_clk) disable iff (!rst_n)
        (reg_req.wr && reg_req.addr == SPST_ADDR_STATUS && !reg_req.rd)
        |=> ($stable(st.power) && $stable(st.task_a) && $stable(st.task_b)))
        else $error("status write changed a register");

    a_status_read_live: assert property (@(posedge core_clk) disable iff (!rst_n)
        (reg_req.rd && reg_req.addr == SPST_ADDR_STATUS) |=> reg_rdata == $past(status_live))
        else $error("status read not live");

    a_marker_copy: assert property (@(posedge core_clk) disable iff (!rst_n)
        (reg_req.rd && reg_req.addr == SPST_ADDR_STATUS && !reg_req.wr)
        |=> reg_rdata[SPST_PWR_MARKER - 1] == programmed_marker)
        else $error("marker copy mismatch");

    a_pin_flag_sync: assert property (@(posedge core_clk) disable iff (!rst_n)
        (reg_req.rd && reg_req.addr == SPST_ADDR_STATUS) ##1 $past(rst_n, 3)
        |-> reg_rdata[7] == $past(xside_tristate_pin, 3))
        else $error("pin flag not two-stage synchronised");

    a_decoder_sleep_write: assert property (@(posedge core_clk) disable iff (!rst_n)
        (reg_req.wr && reg_req.addr == SPST_ADDR_POWER)
        |=> decoder_powerdown == $past(reg_req.wdata[SPST_PWR_DECODER_SLEEP]))
        else $error("decoder sleep not applied");

    a_scaler_sleep_out: assert property (@(posedge core_clk) disable iff (!rst_n)
        scaler_powerdown |-> !image_out_enable && !scaler_run)
        else $error("image output active while scaler asleep");

    a_audio_pd_out: assert property (@(posedge core_clk) disable iff (!rst_n)
        audio_clk_powerdown |-> !audio_clk_out_en)
        else $error("audio output enabled in power-down");

    a_skip_zero_direct: assert property (@(posedge core_clk) disable iff (!rst_n)
        (st.tstate == SPST_TS_IDLE && task_activate && soft_run
         && new_task[SPST_TSK_SKIP_LO +: SPST_TSK_SKIP_W] == 3'h0) |=> task_start)
        else $error("zero skip did not start at once");

    a_skip_last_field: assert property (@(posedge core_clk) disable iff (!rst_n)
        (st.tstate == SPST_TS_SKIP && field_pulse && st.skip_cnt == 3'h1 && soft_run)
        |=> task_start ##1 !task_start)
        else $error("task not started after last skipped field");

    a_toggle_on_start: assert property (@(posedge core_clk) disable iff (!rst_n)
        $rose(task_start) |-> st.toggle != $past(st.toggle))
        else $error("task flag did not toggle");

    a_polarity_bit7: assert property (@(posedge core_clk) disable iff (!rst_n)
        task_start |-> sav_eav_bit7
            == !(st.active_b ? st.task_b[SPST_TSK_POLARITY] : st.task_a[SPST_TSK_POLARITY]))
        else $error("SAV/EAV bit 7 polarity wrong");

    a_soft_reset_idle: assert property (@(posedge core_clk) disable iff (!rst_n)
        !soft_run |=> !task_busy && !task_start)
        else $error("task engine active in soft reset");

    // register port: status flags must reach the read data live, the pin bits through the two-stage synchroniser
    a_image_out_tristate_pin_flag_sync: assert property (@(posedge core_clk) disable iff (!rst_n)
        (reg_req.rd && reg_req.addr == SPST_ADDR_STATUS) ##1 $past(rst_n, 3)
        |-> reg_rdata[6] == $past(image_out_tristate_pin, 3))
        else $error("second pin flag not two-stage synchronised");

    a_fifo_flags_live: assert property (@(posedge core_clk) disable iff (!rst_n)
        (reg_req.rd && reg_req.addr == SPST_ADDR_STATUS)
        |=> reg_rdata[5:4] == $past(scaler_flags[3:2]))
        else $error("fifo flags not live in status");

    a_error_fid_live: assert property (@(posedge core_clk) disable iff (!rst_n)
        (reg_req.rd && reg_req.addr == SPST_ADDR_STATUS)
        |=> reg_rdata[2:1] == $past(scaler_flags[1:0]))
        else $error("error flag or input field id not live in status");

    a_rdata_holds: assert property (@(posedge core_clk) disable iff (!rst_n)
        !reg_req.rd |=> $stable(reg_rdata))
        else $error("read data changed without a read");

    a_audio_pd_write: assert property (@(posedge core_clk) disable iff (!rst_n)
        (reg_req.wr && reg_req.addr == SPST_ADDR_POWER)
        |=> audio_clk_out_en == !$past(reg_req.wdata[SPST_PWR_AUDIO_PD]))
        else $error("audio power-down not applied");

    a_sleep_needs_xport: assert property (@(posedge core_clk) disable iff (!rst_n)
        (decoder_powerdown && !(scaler_src_xport && image_port_clock_xport)) |-> !scaler_run)
        else $error("scaler runs without X port source while decoder asleep");

    // task engine: a request while busy must not reload the pending skip count
    a_busy_refused: assert property (@(posedge core_clk) disable iff (!rst_n)
        (st.tstate == SPST_TS_SKIP && task_activate && soft_run)
        |=> task_busy && st.skip_cnt == $past(st.skip_cnt) - {2'b00, $past(field_pulse)})
        else $error("activation while busy disturbed the skip count");

    a_start_single: assert property (@(posedge core_clk) disable iff (!rst_n)
        task_start |=> !task_start)
        else $error("task start longer than one cycle");

    a_fid_from_input: assert property (@(posedge core_clk) disable iff (!rst_n)
        (!reg_req.wr && !task_activate
         && !(st.active_b ? st.task_b[SPST_TSK_FID_SEL] : st.task_a[SPST_TSK_FID_SEL]))
        |=> output_field_id == $past(scaler_flags.input_field_id))
        else $error("output field id does not follow input field id");

    a_fid_from_toggle: assert property (@(posedge core_clk) disable iff (!rst_n)
        (!reg_req.wr && !task_activate
         && (st.active_b ? st.task_b[SPST_TSK_FID_SEL] : st.task_a[SPST_TSK_FID_SEL]))
        |=> output_field_id == st.toggle)
        else $error("output field id does not carry the task flag");

    c_direct_task: cover property (@(posedge core_clk) disable iff (!rst_n)
        task_activate && !task_busy ##1 task_start);
    c_skipped_task: cover property (@(posedge core_clk) disable iff (!rst_n)
        st.tstate == SPST_TS_SKIP ##1 field_pulse ##[1:20] task_start);
    c_status_read: cover property (@(posedge core_clk) disable iff (!rst_n)
        reg_req.rd && reg_req.addr == SPST_ADDR_STATUS && programmed_marker);
    c_refused_activate: cover property (@(posedge core_clk) disable iff (!rst_n)
        task_busy && task_activate);
    c_soft_reset_drop: cover property (@(posedge core_clk) disable iff (!rst_n)
        task_busy && !soft_run);

endmodule : spst_ctrl

/* testbench/spst_host_model.sv */
// host software model: single-byte writes and reads on the register port
`timescale 1ns/10ps
module spst_host_model
    import spst_pkg::*;
(
    input  wire logic       core_clk,
    output spst_reg_req_t   reg_req,
    input  wire logic [7:0] reg_rdata
);
    initial reg_req = '0;

    // address and data are scrambled once released so a stale value never passes for a new one
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge core_clk);
        reg_req = '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(negedge core_clk);
        reg_req = '{addr: ~a, wdata: ~d, wr: 1'b0, rd: 1'b0};
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge core_clk);
        reg_req = '{addr: a, wdata: 8'h5A, wr: 1'b0, rd: 1'b1};
        @(negedge core_clk);
        reg_req = '{addr: ~a, wdata: 8'hA5, wr: 1'b0, rd: 1'b0};
        d = reg_rdata;
    endtask : rd

    // software marks the end of programming by setting the marker with the power byte
    task automatic set_programmed(input logic [7:0] pwr);
        wr(SPST_ADDR_POWER, pwr | 8'h10);
    endtask : set_programmed
endmodule : spst_host_model

/* testbench/tb_top.sv */
// self-checking bench for the scaler power, status and task control bank
`timescale 1ns/10ps
module tb_top
    import spst_pkg::*;
;
    logic core_clk, rst_n, xpin, ipin, src_x, clk_x, fpulse, tact, tsel_b, tdone, tog;
    logic dec_pd, scl_pd, run, img_en, aud_pd, aud_en, t_start, t_busy, ofid, sav7, tflag;
    spst_reg_req_t      reg_req;
    spst_scaler_flags_t flags;
    logic [7:0]         rdata, rd_v, v;
    logic [1:0]         adc_sel;
    int                 err_total, tests_run, cycles;
    logic [7:0] raddr [5] = '{SPST_ADDR_POWER, SPST_ADDR_STATUS, SPST_ADDR_TASK_A,
                              SPST_ADDR_TASK_B, 8'h55};
    logic [7:0] pcase [4] = '{8'h20, 8'h21, 8'h21, 8'h2A};
    logic [7:0] tcase [4] = '{8'h00, 8'h1F, 8'h09, 8'h13};
    wire  [7:0] obs_pwr = {run, img_en, aud_en, aud_pd, scl_pd, dec_pd, adc_sel};
    wire  [7:0] obs_tsk = {3'h0, t_start, t_busy, ofid, sav7, tflag};

    spst_host_model u_host (.core_clk(core_clk), .reg_req(reg_req), .reg_rdata(rdata));

    spst_ctrl u_dut (
        .core_clk(core_clk), .rst_n(rst_n), .reg_req(reg_req), .reg_rdata(rdata),
        .xside_tristate_pin(xpin), .image_out_tristate_pin(ipin), .scaler_flags(flags),
        .scaler_src_xport(src_x), .image_port_clock_xport(clk_x), .field_pulse(fpulse),
        .task_activate(tact), .task_select_b(tsel_b), .task_done(tdone),
        .decoder_powerdown(dec_pd), .scaler_powerdown(scl_pd), .scaler_run(run),
        .image_out_enable(img_en), .audio_clk_powerdown(aud_pd), .audio_clk_out_en(aud_en),
        .adc_port_select(adc_sel), .task_start(t_start), .task_busy(t_busy),
        .output_field_id(ofid), .sav_eav_bit7(sav7), .task_flag(tflag)
    );

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        tests_run++;
        if (seen !== exp) begin
            err_total++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk

    task automatic give_verdict;
        if (err_total == 0 && tests_run > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : give_verdict

    function automatic logic [7:0] exp_pwr(input logic [7:0] p, input logic sx, input logic cx);
        logic r;
        r = p[5] & ~p[1] & (~p[0] | (sx & cx));
        return {r, r, ~p[3], p[3], p[1], p[0], p[7:6]};
    endfunction : exp_pwr

    // sel=1 everywhere so the toggling task status is visible on the field id output
    task automatic run_task(input logic b, input logic pol, input logic [2:0] skip);
        logic [7:0] treg;
        treg = {pol, 1'b1, skip, 3'h5};
        u_host.wr(b ? SPST_ADDR_TASK_B : SPST_ADDR_TASK_A, treg);
        u_host.rd(b ? SPST_ADDR_TASK_B : SPST_ADDR_TASK_A, rd_v);
        chk(rd_v, treg);
        tact = 1'b1;
        tsel_b = b;
        @(negedge core_clk);
        tact = 1'b0;
        if (skip != 3'h0) chk({6'h0, t_start, t_busy}, 8'h01);
        for (int i = 1; i <= skip; i++) begin
            fpulse = 1'b1;
            tact = (i == 1);
            @(negedge core_clk);
            fpulse = 1'b0;
            tact = 1'b0;
            if (i < skip) begin
                chk({6'h0, t_start, t_busy}, 8'h01);
                @(negedge core_clk);
            end
        end
        tog = ~tog;
        chk(obs_tsk, {3'h0, 2'b11, tog, ~pol, ~pol});
        @(negedge core_clk);
        chk({7'h0, t_start}, 8'h00);
        tdone = 1'b1;
        @(negedge core_clk);
        tdone = 1'b0;
        chk({7'h0, t_busy}, 8'h00);
    endtask : run_task

    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end

    // generous ceiling: the sequence needs well under a thousand cycles
    always @(posedge core_clk) begin
        cycles = cycles + 1;
        if (cycles == 5000) begin
            err_total++;
            give_verdict();
        end
    end

    initial begin
        {rst_n, xpin, ipin, src_x, clk_x, fpulse, tact, tsel_b, tdone, tog} = '0;
        flags = '0;
        err_total = 0;
        tests_run = 0;
        cycles = 0;
        void'($urandom(44));
        repeat (3) @(negedge core_clk);
        rst_n = 1'b1;
        chk(obs_pwr, 8'h20);
        chk(obs_tsk, 8'h03);
        u_host.wr(8'h55, 8'hFF);
        foreach (raddr[i]) begin
            u_host.rd(raddr[i], rd_v);
            chk(rd_v, 8'h00);
        end
        for (int i = 0; i < 12; i++) begin
            v = (i < 4) ? pcase[i] : 8'($urandom);
            {src_x, clk_x} = (i == 2) ? 2'b11 : 2'($urandom);
            u_host.wr(SPST_ADDR_POWER, v);
            chk(obs_pwr, exp_pwr(v, src_x, clk_x));
            u_host.rd(SPST_ADDR_POWER, rd_v);
            chk(rd_v, v);
        end
        u_host.set_programmed(8'h20);
        repeat (6) begin
            v = 8'($urandom);
            {xpin, ipin, flags} = v[7:2];
            u_host.wr(SPST_ADDR_STATUS, ~v);
            repeat (3) @(negedge core_clk);
            u_host.rd(SPST_ADDR_STATUS, rd_v);
            chk(rd_v, {v[7:4], 1'b1, v[3:2], v[2]});
            u_host.rd(SPST_ADDR_POWER, rd_v);
            chk(rd_v, 8'h30);
        end
        flags = '0;
        for (int i = 0; i < 7; i++) begin
            v = (i < 4) ? tcase[i] : 8'($urandom);
            run_task(v[4], v[3], v[2:0]);
        end
        u_host.wr(SPST_ADDR_TASK_A, 8'h18);
        tact = 1'b1;
        tsel_b = 1'b0;
        @(negedge core_clk);
        tact = 1'b0;
        chk({7'h0, t_busy}, 8'h01);
        u_host.wr(SPST_ADDR_POWER, 8'h10);
        @(negedge core_clk);
        chk({5'h0, t_start, t_busy, run}, 8'h00);
        give_verdict();
    end
endmodule : tb_top
